// File: src/mcu_interrupt_prioritizer.sv
// Interrupt prioritizer: edge capture, fixed priority, masking, context push
// sequencing and two-byte vector fetch, plus AXI4-Lite registers.
// Assumes the core pulses insn_boundary before each opcode fetch and
// answers push and vector requests with one-cycle acks.
//
// Behaviour
// - Six sources: reset, software trap, four hardware request lines.
// - Only the highest pending request is granted; others stay pending.
// - Priority: reset, software trap, external/Port B, carrier, timer, serial.
// - Reset vector high byte at FFFE, low byte at FFFF.
// - Software trap vector high byte at FFFC, low byte at FFFD.
// - External/Port B vector high byte at FFFA, low byte at FFFB.
// - Carrier modulator vector high byte at FFF8, low byte at FFF9.
// - Core timer vector high byte at FFF6, low byte at FFF7.
// - Serial interface vector high byte at FFF4, low byte at FFF5.
// - Mask flag set blocks all four hardware request lines.
// - Software trap is never masked; same entry sequence as hardware.
// - External lines are detected on a falling edge.
// - Requests are checked at each instruction boundary before fetch.
// - PC, index, accumulator and status word are pushed before vectoring.
// - The set-mask instruction sets the mask flag to one.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module mcu_interrupt_prioritizer
  import irq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq_n,
  input wire logic [NPB-1:0] portb_pin_n,
  input wire logic carrier_irq,
  input wire logic timer_irq,
  input wire logic serial_irq,
  input wire logic insn_boundary,
  input wire logic soft_trap_instruction,
  input wire logic set_mask_instruction,
  input wire logic clear_mask_instruction,
  input wire logic mask_load,
  input wire logic mask_load_val,
  input wire logic push_ack,
  input wire logic vec_ack,
  input wire logic [7:0] vec_rdata,
  output logic mask_flag,
  output logic int_take,
  output logic [2:0] int_src,
  output logic push_req,
  output logic [2:0] push_sel,
  output logic vec_rd_req,
  output logic [15:0] vec_addr,
  output logic [15:0] new_pc,
  output logic new_pc_valid,
  output logic irq
);

  typedef struct packed {
    seq_e state;
    logic [2:0] cnt;
    logic [2:0] src;
    logic pend_trap;
    logic mask_flag;
    logic [5:0] ev_stat;
    logic [5:0] ev_mask;
    logic [7:0] pb_ctrl;
    logic [7:0] vec_hi;
    logic [15:0] vec_addr;
    logic [15:0] new_pc;
    logic new_pc_valid;
    logic aw_ok;
    logic [7:0] awaddr;
    logic w_ok;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } st_s;

  st_s r, r_nxt;

  logic [NPB:0] edge_pend;
  logic [NPB:0] edge_clr;
  logic ext_pend;
  logic [NSRC-1:0] req;
  logic [2:0] win;
  logic win_any;

  function automatic logic [5:0] reg_idx(input logic [7:0] addr);
    return addr[7:2];
  endfunction

  function automatic logic [15:0] vec_base(input logic [2:0] src);
    logic [15:0] v;
    unique case (src)
      SRC_RESET: v = VEC_RESET;
      SRC_TRAP: v = VEC_TRAP;
      SRC_EXT: v = VEC_EXT;
      SRC_CARRIER: v = VEC_CARRIER;
      SRC_TIMER: v = VEC_TIMER;
      SRC_SERIAL: v = VEC_SERIAL;
      default: v = VEC_RESET;
    endcase
    return v;
  endfunction

  // Bit 0 is the external pin; bits above are the Port B pins
  edge_catcher #(
    .N(NPB + 1)
  ) u_edges (
    .aclk(aclk),
    .aresetn(aresetn),
    .line_n({portb_pin_n, ext_irq_n}),
    .clr(edge_clr),
    .pend(edge_pend)
  );

  // Port B pins count only where their select bit is set
  assign ext_pend = edge_pend[0] | (|(edge_pend[NPB:1] & r.pb_ctrl));

  always_comb begin
    req = '0;
    req[SRC_TRAP] = r.pend_trap;
    req[SRC_EXT] = ext_pend & ~r.mask_flag;
    req[SRC_CARRIER] = carrier_irq & ~r.mask_flag;
    req[SRC_TIMER] = timer_irq & ~r.mask_flag;
    req[SRC_SERIAL] = serial_irq & ~r.mask_flag;
    win = SRC_SERIAL;
    win_any = |req;
    for (int i = NSRC - 1; i >= 1; i--) begin
      if (req[i]) begin
        win = 3'(i);
      end
    end
  end

  assign int_take = (r.state == ST_IDLE) && insn_boundary && win_any;

  always_comb begin
    r_nxt = r;
    r_nxt.new_pc_valid = 1'b0;
    edge_clr = '0;
    push_req = 1'b0;
    vec_rd_req = 1'b0;

    unique case (r.state)
      ST_IDLE: begin
        if (int_take) begin
          r_nxt.src = win;
          r_nxt.cnt = PUSH_PCL;
          r_nxt.state = ST_PUSH;
        end
      end
      ST_PUSH: begin
        push_req = 1'b1;
        if (push_ack) begin
          if (r.cnt == PUSH_PSW) begin
            r_nxt.state = ST_VEC_HI;
            r_nxt.vec_addr = vec_base(r.src);
          end else begin
            r_nxt.cnt = r.cnt + 3'h1;
          end
        end
      end
      ST_VEC_HI: begin
        vec_rd_req = 1'b1;
        if (vec_ack) begin
          r_nxt.vec_hi = vec_rdata;
          r_nxt.vec_addr = vec_base(r.src) | 16'h0001;
          r_nxt.state = ST_VEC_LO;
        end
      end
      ST_VEC_LO: begin
        vec_rd_req = 1'b1;
        if (vec_ack) begin
          r_nxt.new_pc = {r.vec_hi, vec_rdata};
          r_nxt.new_pc_valid = 1'b1;
          r_nxt.state = ST_IDLE;
          if (r.src == SRC_TRAP) begin
            r_nxt.pend_trap = 1'b0;
          end
          if (r.src == SRC_EXT) begin
            edge_clr = '1;
          end
        end
      end
    endcase

    // Software trap held until its vector is taken; set wins
    if (soft_trap_instruction) begin
      r_nxt.pend_trap = 1'b1;
    end

    // Later sources win: restore, then clear, then set, then entry
    if (mask_load) begin
      r_nxt.mask_flag = mask_load_val;
    end
    if (clear_mask_instruction) begin
      r_nxt.mask_flag = 1'b0;
    end
    if (set_mask_instruction) begin
      r_nxt.mask_flag = 1'b1;
    end
    if (int_take) begin
      r_nxt.mask_flag = 1'b1;
    end

    // AXI write channel
    if (s_axi_awvalid && s_axi_awready) begin
      r_nxt.aw_ok = 1'b1;
      r_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_nxt.w_ok = 1'b1;
      r_nxt.wdata = s_axi_wdata[7:0];
      r_nxt.wstrb0 = s_axi_wstrb[0];
    end
    if (r.aw_ok && r.w_ok) begin
      r_nxt.aw_ok = 1'b0;
      r_nxt.w_ok = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = RESP_OKAY;
      unique case (reg_idx(r.awaddr))
        IDX_PB_CTRL: begin
          if (r.wstrb0) begin
            r_nxt.pb_ctrl = r.wdata;
          end
        end
        IDX_EV_STAT: begin
          if (r.wstrb0) begin
            r_nxt.ev_stat = r.ev_stat & ~r.wdata[5:0];
          end
        end
        IDX_EV_MASK: begin
          if (r.wstrb0) begin
            r_nxt.ev_mask = r.wdata[5:0];
          end
        end
        IDX_PEND: begin
          // Read-only view; writes are accepted and dropped
        end
        default: r_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end

    // Event capture after the clear so a same-cycle event is kept
    if (r.new_pc_valid) begin
      r_nxt.ev_stat[r.src] = 1'b1;
    end

    // AXI read channel
    if (s_axi_arvalid && s_axi_arready) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp = RESP_OKAY;
      r_nxt.rdata = 32'h00000000;
      unique case (reg_idx(s_axi_araddr))
        IDX_PB_CTRL: r_nxt.rdata[7:0] = r.pb_ctrl;
        IDX_EV_STAT: r_nxt.rdata[5:0] = r.ev_stat;
        IDX_EV_MASK: r_nxt.rdata[5:0] = r.ev_mask;
        IDX_PEND: r_nxt.rdata[5:0] = req;
        default: r_nxt.rresp = RESP_SLVERR;
      endcase
    end else if (r.rvalid && s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
  end

  // Reset vector is fetched first, with no context to push
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.state <= ST_VEC_HI;
      r.src <= SRC_RESET;
      r.vec_addr <= VEC_RESET;
      r.mask_flag <= MASK_FLAG_RST;
      r.ev_mask <= EV_MASK_RST;
      r.pb_ctrl <= PB_CTRL_RST;
    end else begin
      r <= r_nxt;
    end
  end

  // Holding write handshakes while a response waits keeps one write in flight
  assign s_axi_awready = !r.aw_ok && !r.bvalid;
  assign s_axi_wready = !r.w_ok && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  assign mask_flag = r.mask_flag;
  assign int_src = r.src;
  assign push_sel = r.cnt;
  assign vec_addr = r.vec_addr;
  assign new_pc = r.new_pc;
  assign new_pc_valid = r.new_pc_valid;
  assign irq = |(r.ev_stat & r.ev_mask);

endmodule

// File: pkg/irq_pkg.sv
// Constants, encodings and state types for the interrupt prioritizer.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register bus.
package irq_pkg;

  localparam int NSRC = 6;
  localparam int NPB = 8;

  // Source numbers, highest priority first
  localparam logic [2:0] SRC_RESET = 3'h0;
  localparam logic [2:0] SRC_TRAP = 3'h1;
  localparam logic [2:0] SRC_EXT = 3'h2;
  localparam logic [2:0] SRC_CARRIER = 3'h3;
  localparam logic [2:0] SRC_TIMER = 3'h4;
  localparam logic [2:0] SRC_SERIAL = 3'h5;

  // Vector high-byte addresses; the low byte sits one above
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_EXT = 16'hFFFA;
  localparam logic [15:0] VEC_CARRIER = 16'hFFF8;
  localparam logic [15:0] VEC_TIMER = 16'hFFF6;
  localparam logic [15:0] VEC_SERIAL = 16'hFFF4;

  // Context push order
  localparam logic [2:0] PUSH_PCL = 3'h0;
  localparam logic [2:0] PUSH_PCH = 3'h1;
  localparam logic [2:0] PUSH_X = 3'h2;
  localparam logic [2:0] PUSH_A = 3'h3;
  localparam logic [2:0] PUSH_PSW = 3'h4;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PB_CTRL = 6'h0A;
  localparam logic [5:0] IDX_EV_STAT = 6'h20;
  localparam logic [5:0] IDX_EV_MASK = 6'h21;
  localparam logic [5:0] IDX_PEND = 6'h22;

  localparam logic [7:0] PB_CTRL_RST = 8'h00;
  localparam logic [5:0] EV_MASK_RST = 6'h00;
  localparam logic MASK_FLAG_RST = 1'b1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_VEC_HI, ST_VEC_LO} seq_e;

endpackage

// File: src/edge_catcher.sv
// Falling-edge request catcher with per-line pending hold.
// Assumes lines come from pins: each passes two flip-flops first.
`timescale 1ns/1ps
module edge_catcher
  import irq_pkg::*;
#(
  parameter int N = 9
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N-1:0] line_n,
  input wire logic [N-1:0] clr,
  output logic [N-1:0] pend
);

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] s3;
    logic [N-1:0] pend;
  } ec_s;

  ec_s r, r_nxt;

  always_comb begin
    r_nxt = r;
    r_nxt.s1 = line_n;
    r_nxt.s2 = r.s1;
    r_nxt.s3 = r.s2;
    for (int i = 0; i < N; i++) begin
      if (clr[i]) begin
        r_nxt.pend[i] = 1'b0;
      end
      // Set beats clear so an edge in the clearing cycle survives
      if (r.s3[i] && !r.s2[i]) begin
        r_nxt.pend[i] = 1'b1;
      end
    end
  end

  // Synchronisers idle high so release of reset is no edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{s1: '1, s2: '1, s3: '1, pend: '0};
    end else begin
      r <= r_nxt;
    end
  end

  assign pend = r.pend;

endmodule

// File: sim/mcu_interrupt_prioritizer_sva.sv
// Checker for core-side entry, masking and vector fetch.
// Assumes binding onto the top module; sees its ports only.
`timescale 1ns/1ps
module irq_prio_chk
  import irq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic insn_boundary,
  input wire logic set_mask_instruction,
  input wire logic push_ack,
  input wire logic vec_ack,
  input wire logic mask_flag,
  input wire logic int_take,
  input wire logic [2:0] int_src,
  input wire logic push_req,
  input wire logic [2:0] push_sel,
  input wire logic vec_rd_req,
  input wire logic [15:0] vec_addr,
  input wire logic new_pc_valid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence hi_taken;
    vec_rd_req && vec_ack && !vec_addr[0];
  endsequence
  sequence lo_taken;
    vec_rd_req && vec_ack && vec_addr[0];
  endsequence
  take_sets_mask_a: assert property (int_take |=> mask_flag)
    else $error("mask flag not set by entry");
  set_mask_a: assert property (set_mask_instruction |=> mask_flag)
    else $error("mask flag not set");
  take_boundary_a: assert property (int_take |-> insn_boundary)
    else $error("entry off a boundary");
  push_from_take_a: assert property ($rose(push_req) |-> $past(int_take) && $past(insn_boundary))
    else $error("push without entry");
  busy_no_take_a: assert property (push_req || vec_rd_req |-> !int_take)
    else $error("entry while busy");
  push_start_a: assert property (int_take |=> push_req && push_sel == PUSH_PCL)
    else $error("push not started");
  masked_trap_a: assert property (int_take && mask_flag |=> int_src == SRC_TRAP)
    else $error("masked line taken");
  push_to_vec_a: assert property (push_req && push_ack && push_sel == PUSH_PSW
    |=> vec_rd_req && !push_req)
    else $error("vector read not after push");
  vec_base_a: assert property (vec_rd_req && !vec_addr[0]
    |-> vec_addr == 16'hFFFE - {12'h000, int_src, 1'h0})
    else $error("wrong vector address");
  lo_follows_a: assert property (hi_taken |=> vec_addr == $past(vec_addr) + 16'h0001)
    else $error("low byte address wrong");
  pc_valid_a: assert property (lo_taken |=> new_pc_valid && !vec_rd_req)
    else $error("new pc not flagged");
endmodule

bind mcu_interrupt_prioritizer irq_prio_chk u_chk (.aclk, .aresetn, .insn_boundary,
  .set_mask_instruction, .push_ack, .vec_ack, .mask_flag, .int_take, .int_src, .push_req,
  .push_sel, .vec_rd_req, .vec_addr, .new_pc_valid);

// File: sim/core_model.sv
// Core sequencer stand-in: acks pushes and vector byte reads.
// Assumes one clock; dly adds wait cycles before each ack.
`timescale 1ns/1ps
module core_model (
  input wire logic aclk,
  input wire logic [3:0] dly,
  input wire logic push_req,
  input wire logic vec_rd_req,
  input wire logic [15:0] vec_addr,
  output logic push_ack,
  output logic vec_ack,
  output logic [7:0] vec_rdata
);
  logic [3:0] cnt_r = 4'h0;
  initial push_ack = 1'h0;
  initial vec_ack = 1'h0;
  initial vec_rdata = 8'h00;
  always @(posedge aclk) begin
    push_ack <= 1'h0;
    vec_ack <= 1'h0;
    vec_rdata <= ~vec_rdata; // Data bus not held outside a read
    if ((push_req || vec_rd_req) && !push_ack && !vec_ack) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r >= dly) begin
        cnt_r <= 4'h0;
        push_ack <= push_req;
        vec_ack <= vec_rd_req && !push_req;
        vec_rdata <= vec_addr[7:0];
      end
    end
  end
endmodule

// File: sim/tb_mcu_interrupt_prioritizer.sv
// Testbench: AXI4-Lite master, core model and request lines.
// Assumes core_model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_mcu_interrupt_prioritizer
  import irq_pkg::*;
();
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, ext_irq_n = 1, carrier_irq = 0, timer_irq = 0;
  logic serial_irq = 0, insn_boundary = 0, soft_trap_instruction = 0, set_mask_instruction = 0;
  logic clear_mask_instruction = 0, mask_load = 0, mask_load_val = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, portb_pin_n = 8'hFF;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF, dly = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic push_ack, vec_ack, push_req, vec_rd_req, mask_flag, int_take, new_pc_valid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [2:0] int_src, push_sel;
  logic [7:0] vec_rdata;
  logic [15:0] vec_addr, new_pc;
  int err_count = 0, n_checks = 0;

  always #4 aclk = ~aclk;

  mcu_interrupt_prioritizer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_n, .portb_pin_n,
    .carrier_irq, .timer_irq, .serial_irq, .insn_boundary, .soft_trap_instruction,
    .set_mask_instruction, .clear_mask_instruction, .mask_load, .mask_load_val, .push_ack,
    .vec_ack, .vec_rdata, .mask_flag, .int_take, .int_src, .push_req, .push_sel,
    .vec_rd_req, .vec_addr, .new_pc, .new_pc_valid, .irq);
  core_model u_core (.aclk, .dly, .push_req, .vec_rd_req, .vec_addr, .push_ack, .vec_ack,
    .vec_rdata);

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic guard(input int n);
    if (n >= 80) begin
      err_count++;
      $display("BAD wait exp done got timeout");
      final_report();
    end
  endtask

  // Requests held until their own ready; bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 80);
    s_axi_bready <= 1'h0;
    rs = s_axi_bresp;
    guard(n);
  endtask

  task automatic rd_t(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 80);
    s_axi_rready <= 1'h0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    guard(n);
  endtask

  task automatic wait_pc(input logic [15:0] b);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!new_pc_valid && n < 80);
    guard(n);
    chk("new_pc", {b[7:0], b[7:0] + 8'h01}, new_pc);
  endtask

  task automatic entry(input logic [15:0] b, input logic tk);
    @(posedge aclk);
    insn_boundary <= 1'h1;
    @(negedge aclk);
    chk("int_take", tk, int_take);
    @(posedge aclk);
    insn_boundary <= 1'h0;
    if (tk) wait_pc(b);
  endtask

  task automatic unmask();
    @(posedge aclk);
    clear_mask_instruction <= 1'h1;
    @(posedge aclk);
    clear_mask_instruction <= 1'h0;
  endtask

  task automatic t_reset();
    wait_pc(VEC_RESET);
    chk("mask_flag", MASK_FLAG_RST, mask_flag);
    $display("reset vector test done");
  endtask

  task automatic t_regs();
    wr({IDX_PB_CTRL, 2'h0}, 32'hA5);
    rd_t({IDX_PB_CTRL, 2'h0});
    chk("pb_ctrl", 32'hA5, rd);
    wr(8'h3C, 32'h1);
    chk("bresp", RESP_SLVERR, rs);
    rd_t(8'h3C);
    chk("rresp", RESP_SLVERR, rs);
    wr({IDX_PB_CTRL, 2'h0}, 32'h0);
    $display("register test done");
  endtask

  task automatic t_prio();
    logic [15:0] base [4];
    base = '{VEC_EXT, VEC_CARRIER, VEC_TIMER, VEC_SERIAL};
    unmask();
    {serial_irq, timer_irq, carrier_irq} <= 3'h7;
    soft_trap_instruction <= 1'h1;
    ext_irq_n <= 1'h0;
    @(posedge aclk);
    soft_trap_instruction <= 1'h0;
    repeat (6) @(posedge aclk);
    rd_t({IDX_PEND, 2'h0});
    chk("pending", 32'h3E, rd);
    entry(VEC_TRAP, 1'h1);
    entry(VEC_TRAP, 1'h0);
    for (int i = 0; i < 4; i++) begin
      unmask();
      entry(base[i], 1'h1);
      if (i > 0) {serial_irq, timer_irq, carrier_irq} <= {serial_irq, timer_irq, carrier_irq} << 1;
    end
    unmask();
    entry(VEC_EXT, 1'h0);
    $display("priority test done");
  endtask

  task automatic t_mask();
    dly <= 4'h3;
    set_mask_instruction <= 1'h1;
    serial_irq <= 1'h1;
    ext_irq_n <= 1'h1;
    @(posedge aclk);
    set_mask_instruction <= 1'h0;
    repeat (2) @(posedge aclk);
    ext_irq_n <= 1'h0;
    repeat (6) @(posedge aclk);
    entry(VEC_SERIAL, 1'h0);
    serial_irq <= 1'h0;
    mask_load <= 1'h1;
    @(posedge aclk);
    mask_load <= 1'h0;
    @(negedge aclk);
    chk("mask_flag", 1'h0, mask_flag);
    entry(VEC_EXT, 1'h1);
    wr({IDX_PB_CTRL, 2'h0}, 32'h01);
    portb_pin_n <= 8'hFE;
    repeat (6) @(posedge aclk);
    unmask();
    entry(VEC_EXT, 1'h1);
    dly <= 4'h0;
    $display("mask test done");
  endtask

  task automatic t_events();
    wr({IDX_EV_MASK, 2'h0}, 32'h0);
    @(negedge aclk);
    chk("irq", 1'h0, irq);
    wr({IDX_EV_MASK, 2'h0}, 32'h3E);
    rd_t({IDX_EV_STAT, 2'h0});
    chk("ev_stat", 32'h3E, rd & 32'h3E);
    chk("irq", 1'h1, irq);
    wr({IDX_EV_STAT, 2'h0}, 32'h3F);
    @(negedge aclk);
    chk("irq", 1'h0, irq);
    $display("event test done");
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_regs();
    t_prio();
    t_mask();
    t_events();
    final_report();
  end
endmodule
